/* rtl/pwm_settings_top.sv */
// register file for the two channel settings words and the two channel engines
// assumes the serial decoder gives one-cycle write and read strobes with a word address
`timescale 1ns/1ps
module pwm_settings_top
  import pwm_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         ext_tick,
  input  wire pwm_pkg::addr_t reg_addr,
  input  wire pwm_pkg::word_t reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output pwm_pkg::word_t    reg_rdata,
  input  wire logic         ch1_brake_high,
  input  wire logic [1:0]   ch1_div,
  input  wire pwm_pkg::cnt_t ch1_delay,
  input  wire logic [1:0]   ch2_mode,
  input  wire pwm_pkg::cnt_t ch2_period,
  input  wire pwm_pkg::cnt_t ch2_duty,
  input  wire logic         ch2_brake_high,
  output logic [1:0]        bridge_outputs_a_hs,
  output logic [1:0]        bridge_outputs_a_ls,
  output logic [1:0]        bridge_outputs_b_hs,
  output logic [1:0]        bridge_outputs_b_ls
);
  import pwm_pkg::*;

  typedef struct packed {
    word_t chan2_clock_delay_cfg;
    word_t chan1_mode_period_duty_cfg;
    word_t rdata;
  } regs_s;

  regs_s st_q;
  regs_s st_d;

  always_comb begin
    st_d = st_q;
    if (reg_wr && reg_addr == ADDR_CH2_CLK_DLY) begin
      st_d.chan2_clock_delay_cfg = reg_wdata & CH2_MASK;
    end
    // channel 1 divider and delay share the mode word layout of bits 31:30 and 18:8 elsewhere
    if (reg_wr && reg_addr == ADDR_CH1_MODE) begin
      st_d.chan1_mode_period_duty_cfg = reg_wdata & CH1_MASK;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CH2_CLK_DLY: begin
          st_d.rdata = st_q.chan2_clock_delay_cfg;
        end
        ADDR_CH1_MODE: begin
          st_d.rdata = st_q.chan1_mode_period_duty_cfg;
        end
        default: begin
          st_d.rdata = RST_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= '{default: RST_WORD};
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;

  // channel 1 divider and delay live in a neighbouring word, so they arrive as levels like channel 2 mode
  pwm_cfg_if cfg_a ();
  pwm_cfg_if cfg_b ();

  assign cfg_a.div        = ch1_div;
  assign cfg_a.delay      = ch1_delay;
  assign cfg_a.mode       = st_q.chan1_mode_period_duty_cfg[MODE_MSB:MODE_LSB];
  assign cfg_a.period     = st_q.chan1_mode_period_duty_cfg[PERIOD_MSB:PERIOD_LSB];
  assign cfg_a.duty       = st_q.chan1_mode_period_duty_cfg[DUTY_MSB:DUTY_LSB];
  assign cfg_a.brake_high = ch1_brake_high;

  assign cfg_b.div        = st_q.chan2_clock_delay_cfg[DIV_MSB:DIV_LSB];
  assign cfg_b.delay      = st_q.chan2_clock_delay_cfg[DLY_MSB:DLY_LSB];
  assign cfg_b.mode       = ch2_mode;
  assign cfg_b.period     = ch2_period;
  assign cfg_b.duty       = ch2_duty;
  assign cfg_b.brake_high = ch2_brake_high;

  pwm_channel u_chan_a (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .ext_tick (ext_tick),
    .cfg      (cfg_a),
    .out_hs   (bridge_outputs_a_hs),
    .out_ls   (bridge_outputs_a_ls)
  );

  pwm_channel u_chan_b (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .ext_tick (ext_tick),
    .cfg      (cfg_b),
    .out_hs   (bridge_outputs_b_hs),
    .out_ls   (bridge_outputs_b_ls)
  );

  property p_ch2_write;
    @(posedge ref_clk) disable iff (rst)
      (reg_wr && reg_addr == ADDR_CH2_CLK_DLY)
      |=> (cfg_b.div == $past(reg_wdata[DIV_MSB:DIV_LSB]) && cfg_b.delay == $past(reg_wdata[DLY_MSB:DLY_LSB]));
  endproperty
  a_ch2_write: assert property (p_ch2_write) else $error("channel 2 fields not stored");

  property p_ch1_write;
    @(posedge ref_clk) disable iff (rst)
      (reg_wr && reg_addr == ADDR_CH1_MODE)
      |=> (cfg_a.period == $past(reg_wdata[PERIOD_MSB:PERIOD_LSB]) && cfg_a.duty == $past(reg_wdata[DUTY_MSB:DUTY_LSB]));
  endproperty
  a_ch1_write: assert property (p_ch1_write) else $error("channel 1 period or duty not stored");

  property p_reserved_zero;
    @(posedge ref_clk) disable iff (rst)
      (reg_rd && reg_addr == ADDR_CH2_CLK_DLY) |=> ((reg_rdata & ~CH2_MASK) == RST_WORD);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read non zero");

  property p_pair_b_off;
    @(posedge ref_clk) disable iff (rst)
      (ch2_mode == MODE_OFF) [*3] |-> (bridge_outputs_b_hs == 2'b00 && bridge_outputs_b_ls == 2'b00);
  endproperty
  a_pair_b_off: assert property (p_pair_b_off) else $error("pair b driven while channel 2 off");

  property p_ch2_hold;
    @(posedge ref_clk) disable iff (rst)
      !(reg_wr && reg_addr == ADDR_CH2_CLK_DLY) |=> $stable(st_q.chan2_clock_delay_cfg);
  endproperty
  a_ch2_hold: assert property (p_ch2_hold) else $error("channel 2 word changed without a write");

  property p_ch1_hold;
    @(posedge ref_clk) disable iff (rst)
      !(reg_wr && reg_addr == ADDR_CH1_MODE) |=> $stable(st_q.chan1_mode_period_duty_cfg);
  endproperty
  a_ch1_hold: assert property (p_ch1_hold) else $error("channel 1 word changed without a write");

  property p_rd_ch2;
    @(posedge ref_clk) disable iff (rst)
      (reg_rd && reg_addr == ADDR_CH2_CLK_DLY) |=> (reg_rdata == $past(st_q.chan2_clock_delay_cfg));
  endproperty
  a_rd_ch2: assert property (p_rd_ch2) else $error("channel 2 word read back wrong");

  property p_rd_ch1;
    @(posedge ref_clk) disable iff (rst)
      (reg_rd && reg_addr == ADDR_CH1_MODE) |=> (reg_rdata == $past(st_q.chan1_mode_period_duty_cfg));
  endproperty
  a_rd_ch1: assert property (p_rd_ch1) else $error("channel 1 word read back wrong");

  property p_rd_other;
    @(posedge ref_clk) disable iff (rst)
      (reg_rd && reg_addr != ADDR_CH2_CLK_DLY && reg_addr != ADDR_CH1_MODE) |=> (reg_rdata == RST_WORD);
  endproperty
  a_rd_other: assert property (p_rd_other) else $error("unmapped address read non zero");

  property p_rd_hold;
    @(posedge ref_clk) disable iff (rst)
      !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");

  property p_ch2_reserved;
    @(posedge ref_clk) disable iff (rst)
      (st_q.chan2_clock_delay_cfg & ~CH2_MASK) == RST_WORD;
  endproperty
  a_ch2_reserved: assert property (p_ch2_reserved) else $error("channel 2 reserved bits stored");

  property p_ch1_reserved;
    @(posedge ref_clk) disable iff (rst)
      (st_q.chan1_mode_period_duty_cfg & ~CH1_MASK) == RST_WORD;
  endproperty
  a_ch1_reserved: assert property (p_ch1_reserved) else $error("channel 1 reserved bits stored");

  property p_pair_a_off;
    @(posedge ref_clk) disable iff (rst)
      (st_q.chan1_mode_period_duty_cfg[MODE_MSB:MODE_LSB] == MODE_OFF) [*3] |-> (bridge_outputs_a_hs == 2'b00 && bridge_outputs_a_ls == 2'b00);
  endproperty
  a_pair_a_off: assert property (p_pair_a_off) else $error("pair a driven while channel 1 off");

  property p_pair_a_legs;
    @(posedge ref_clk) disable iff (rst)
      (bridge_outputs_a_hs & bridge_outputs_a_ls) == 2'b00;
  endproperty
  a_pair_a_legs: assert property (p_pair_a_legs) else $error("pair a leg has both gates on");

  property p_pair_b_legs;
    @(posedge ref_clk) disable iff (rst)
      (bridge_outputs_b_hs & bridge_outputs_b_ls) == 2'b00;
  endproperty
  a_pair_b_legs: assert property (p_pair_b_legs) else $error("pair b leg has both gates on");

  property p_pair_a_fwd;
    @(posedge ref_clk) disable iff (rst)
      (bridge_outputs_a_hs == 2'b01) |-> (bridge_outputs_a_ls == 2'b10);
  endproperty
  a_pair_a_fwd: assert property (p_pair_a_fwd) else $error("pair a forward legs mismatched");

  property p_pair_b_fwd;
    @(posedge ref_clk) disable iff (rst)
      (bridge_outputs_b_hs == 2'b01) |-> (bridge_outputs_b_ls == 2'b10);
  endproperty
  a_pair_b_fwd: assert property (p_pair_b_fwd) else $error("pair b forward legs mismatched");

  property p_pair_a_rev;
    @(posedge ref_clk) disable iff (rst)
      (bridge_outputs_a_hs == 2'b10) |-> (bridge_outputs_a_ls == 2'b01);
  endproperty
  a_pair_a_rev: assert property (p_pair_a_rev) else $error("pair a reverse legs mismatched");

  property p_pair_b_rev;
    @(posedge ref_clk) disable iff (rst)
      (bridge_outputs_b_hs == 2'b10) |-> (bridge_outputs_b_ls == 2'b01);
  endproperty
  a_pair_b_rev: assert property (p_pair_b_rev) else $error("pair b reverse legs mismatched");

  c_ch1_write: cover property (@(posedge ref_clk) disable iff (rst) reg_wr && reg_addr == ADDR_CH1_MODE);
  c_read: cover property (@(posedge ref_clk) disable iff (rst) reg_rd ##1 reg_rdata != RST_WORD);
endmodule

/* rtl/pwm_pkg.sv */
// constants, field layouts and helpers for the two-channel serial-controlled bridge pwm block
// assumes the serial frame decoder presents one 32-bit word per register write
// Overview of operation
// - base clock divides by 1, 2, 4, 20
// - per-channel eleven-bit on-delay before drive turn-on
// - mode: off, forward, reverse, brake
// - brake side picked by separate select bit
// - period lasts period count plus one cycles
// - period and duty counters run on base tick
// - drive active for duty count base cycles
// - duty equal to period gives full drive
// - duty above period still gives full drive
// - zero duty keeps drive inactive all period
// - channel 2 on pair b, channel 1 pair a
// - channel 1 has own divider and delay fields
package pwm_pkg;
  localparam int unsigned CNT_W      = 11;
  localparam int unsigned DIV_W      = 5;
  localparam int unsigned ADDR_W     = 7;
  localparam int unsigned DATA_W     = 32;
  typedef logic [CNT_W-1:0]  cnt_t;
  typedef logic [DIV_W-1:0]  div_t;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] word_t;

  localparam addr_t ADDR_CH2_CLK_DLY = 7'h06;
  localparam addr_t ADDR_CH1_MODE    = 7'h07;

  localparam int unsigned DIV_MSB    = 31;
  localparam int unsigned DIV_LSB    = 30;
  localparam int unsigned MODE_MSB   = 31;
  localparam int unsigned MODE_LSB   = 30;
  localparam int unsigned PERIOD_MSB = 29;
  localparam int unsigned PERIOD_LSB = 19;
  localparam int unsigned DLY_MSB    = 18;
  localparam int unsigned DLY_LSB    = 8;
  localparam int unsigned DUTY_MSB   = 18;
  localparam int unsigned DUTY_LSB   = 8;

  localparam word_t RST_WORD = 32'h0000_0000;
  localparam word_t CH2_MASK = 32'hC007_FF00;
  localparam word_t CH1_MASK = 32'hFFFF_FF00;

  localparam logic [1:0] DIV_BY1    = 2'h0;
  localparam logic [1:0] DIV_BY2    = 2'h1;
  localparam logic [1:0] DIV_BY4    = 2'h2;
  localparam div_t       RATIO_1    = 5'h01;
  localparam div_t       RATIO_2    = 5'h02;
  localparam div_t       RATIO_4    = 5'h04;
  localparam div_t       RATIO_20   = 5'h14;

  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_FWD   = 2'h1;
  localparam logic [1:0] MODE_REV   = 2'h2;
  localparam logic [1:0] MODE_BRAKE = 2'h3;

  function automatic div_t div_ratio(input logic [1:0] code);
    div_t r;
    r = RATIO_20;
    if (code == DIV_BY1) begin
      r = RATIO_1;
    end else if (code == DIV_BY2) begin
      r = RATIO_2;
    end else if (code == DIV_BY4) begin
      r = RATIO_4;
    end
    return r;
  endfunction
endpackage

/* rtl/pwm_cfg_if.sv */
// settings of one bridge channel as passed from the register file to a channel engine
// assumes the register file drives every field as a static level
`timescale 1ns/1ps
interface pwm_cfg_if;
  import pwm_pkg::*;
  logic [1:0] div;
  cnt_t       delay;
  logic [1:0] mode;
  cnt_t       period;
  cnt_t       duty;
  logic       brake_high;
  modport src (output div, output delay, output mode, output period, output duty, output brake_high);
  modport snk (input div, input delay, input mode, input period, input duty, input brake_high);
endinterface

/* rtl/pwm_channel.sv */
// one bridge channel: base divider, on-delay, period/duty counter, gate outputs
// assumes ext_tick is a one-cycle pulse per external input clock period
`timescale 1ns/1ps
module pwm_channel
  import pwm_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic ext_tick,
  pwm_cfg_if.snk    cfg,
  output logic [1:0] out_hs,
  output logic [1:0] out_ls
);
  import pwm_pkg::*;

  typedef struct packed {
    div_t       div_cnt;
    cnt_t       cnt;
    cnt_t       per;
    cnt_t       duty;
    logic [1:0] mode;
    cnt_t       dly;
    logic [1:0] hs;
    logic [1:0] ls;
  } chan_s;

  chan_s st_q;
  chan_s st_d;
  logic  base_tick;
  logic  on_phase;

  // >= lets a shortened ratio act on the next tick instead of waiting for the count to wrap
  assign base_tick = ext_tick && (st_q.div_cnt >= div_t'(div_ratio(cfg.div) - RATIO_1));
  // zero duty wins over the full-duty clamp so period 0 with duty 0 stays off
  assign on_phase = (st_q.duty != '0) && ((st_q.duty >= st_q.per) || (st_q.cnt < st_q.duty));

  always_comb begin
    st_d = st_q;
    if (ext_tick) begin
      st_d.div_cnt = base_tick ? '0 : div_t'(st_q.div_cnt + RATIO_1);
    end
    if (base_tick) begin
      if (st_q.cnt >= st_q.per) begin
        st_d.cnt  = '0;
        st_d.per  = cfg.period;
        st_d.duty = cfg.duty;
      end else begin
        st_d.cnt = cnt_t'(st_q.cnt + 1'b1);
      end
      if (st_q.dly != '0) begin
        st_d.dly = cnt_t'(st_q.dly - 1'b1);
      end
    end
    // a mode change restarts the turn-on delay; the bridge stays open meanwhile
    if (cfg.mode != st_q.mode) begin
      st_d.mode = cfg.mode;
      st_d.dly  = cfg.delay;
    end
    st_d.hs = '0;
    st_d.ls = '0;
    if (st_q.dly == '0) begin
      unique case (st_q.mode)
        MODE_OFF: begin
          st_d.hs = '0;
        end
        MODE_FWD: begin
          st_d.hs = on_phase ? 2'b01 : 2'b00;
          st_d.ls = on_phase ? 2'b10 : 2'b11;
        end
        MODE_REV: begin
          st_d.hs = on_phase ? 2'b10 : 2'b00;
          st_d.ls = on_phase ? 2'b01 : 2'b11;
        end
        MODE_BRAKE: begin
          st_d.hs = cfg.brake_high ? 2'b11 : 2'b00;
          st_d.ls = cfg.brake_high ? 2'b00 : 2'b11;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign out_hs = st_q.hs;
  assign out_ls = st_q.ls;

  property p_div_one;
    @(posedge ref_clk) disable iff (rst)
      (ext_tick && cfg.div == DIV_BY1) |-> base_tick;
  endproperty
  a_div_one: assert property (p_div_one) else $error("divide by one missed a tick");

  property p_wrap;
    @(posedge ref_clk) disable iff (rst)
      (base_tick && st_q.cnt == st_q.per) |=> (st_q.cnt == '0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("period counter did not wrap");

  property p_latch_boundary;
    @(posedge ref_clk) disable iff (rst)
      !$stable(st_q.per) |-> $past(base_tick && (st_q.cnt >= st_q.per));
  endproperty
  a_latch_boundary: assert property (p_latch_boundary) else $error("period changed mid cycle");

  property p_zero_duty;
    @(posedge ref_clk) disable iff (rst)
      (st_q.mode == MODE_FWD && st_q.dly == '0 && st_q.duty == '0) |=> (out_hs == 2'b00 && out_ls == 2'b11);
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("zero duty drove high side");

  property p_full_duty;
    @(posedge ref_clk) disable iff (rst)
      (st_q.mode == MODE_FWD && st_q.dly == '0 && st_q.duty != '0 && st_q.duty >= st_q.per)
      |=> (out_hs == 2'b01);
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("full duty dropped drive");

  property p_mode_off;
    @(posedge ref_clk) disable iff (rst)
      (st_q.mode == MODE_OFF) |=> (out_hs == 2'b00 && out_ls == 2'b00);
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("off mode drove a gate");

  property p_brake_high;
    @(posedge ref_clk) disable iff (rst)
      (st_q.mode == MODE_BRAKE && st_q.dly == '0 && cfg.brake_high) |=> (out_hs == 2'b11 && out_ls == 2'b00);
  endproperty
  a_brake_high: assert property (p_brake_high) else $error("high side brake wrong");

  property p_delay_load;
    @(posedge ref_clk) disable iff (rst)
      (cfg.mode != st_q.mode) |=> (st_q.dly == $past(cfg.delay));
  endproperty
  a_delay_load: assert property (p_delay_load) else $error("on delay not loaded");

  c_fwd_pwm: cover property (@(posedge ref_clk) disable iff (rst) $rose(out_hs[0]) ##[1:1000] $fell(out_hs[0]));
  c_brake: cover property (@(posedge ref_clk) disable iff (rst) st_q.mode == MODE_BRAKE && st_q.dly == '0);
  c_div20: cover property (@(posedge ref_clk) disable iff (rst) base_tick && cfg.div == 2'h3);
endmodule

/* tb/dc_motor_model.sv */
// behavioural brushed motor across one bridge pair; counts cycles in which a leg has both gates on
// assumes gate enables are registered on ref_clk and active high
`timescale 1ns/1ps
module dc_motor_model (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [1:0] hs,
  input  wire logic [1:0] ls,
  output int              shoot
);
  // a leg with both gates on shorts the supply; only counted, no current is modelled
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shoot <= 0;
    end else if ((hs & ls) !== 2'h0) begin
      shoot <= shoot + 1;
    end
  end
endmodule

/* tb/spi_motor_pwm_settings_tb.sv */
// self-checking bench for the bridge pwm settings block with one motor model per pair
// assumes ext_tick held high, so a base tick is one ref_clk cycle per divider count, except in one half-rate test
`timescale 1ns/1ps
module spi_motor_pwm_settings_tb;
  import pwm_pkg::*;
  typedef struct {addr_t a; word_t w; word_t r; logic bh; logic [3:0] p; int n;} row_s;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       ext_tick = 1'b1;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       ch1_brake_high = 1'b0;
  logic [1:0] ch1_div = 2'h0;
  cnt_t       ch1_delay = '0;
  logic       ch2_brake_high = 1'b0;
  addr_t      reg_addr = '0;
  word_t      reg_wdata = '0;
  word_t      reg_rdata;
  word_t      v;
  logic [1:0] ch2_mode = 2'h0;
  logic [1:0] a_hs, a_ls, b_hs, b_ls;
  cnt_t       ch2_period = '0;
  cnt_t       ch2_duty = '0;
  int         n_fail = 0;
  int         total_checks = 0;
  int         sa, sb, na, nb;
  int         ratio [4] = '{1, 2, 4, 20};
  // gate pattern is {hs, ls}; counts are over 40 base ticks of a 4-tick period
  row_s rows [11] = '{
    '{7'h06, 32'hFFFF_FFFF, 32'hC007_FF00, 1'b0, 4'h0, 40},
    '{7'h06, 32'h0000_0000, 32'h0000_0000, 1'b0, 4'h0, 40},
    '{7'h05, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0, 4'h0, 40},
    '{7'h07, 32'hC018_03FF, 32'hC018_0300, 1'b1, 4'hC, 40},
    '{7'h07, 32'hC018_0300, 32'hC018_0300, 1'b0, 4'h3, 40},
    '{7'h07, 32'h4018_0200, 32'h4018_0200, 1'b0, 4'h6, 20},
    '{7'h07, 32'h4018_0300, 32'h4018_0300, 1'b0, 4'h6, 40},
    '{7'h07, 32'h4018_0500, 32'h4018_0500, 1'b0, 4'h6, 40},
    '{7'h07, 32'h4018_0000, 32'h4018_0000, 1'b0, 4'h6, 0},
    '{7'h07, 32'h8018_0200, 32'h8018_0200, 1'b0, 4'h9, 20},
    '{7'h07, 32'h0018_0200, 32'h0018_0200, 1'b0, 4'h0, 40}
  };

  always #4 ref_clk = ~ref_clk;

  pwm_settings_top uut (
    .ref_clk(ref_clk), .rst(rst), .ext_tick(ext_tick), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ch1_brake_high(ch1_brake_high), .ch1_div(ch1_div), .ch1_delay(ch1_delay),
    .ch2_mode(ch2_mode), .ch2_period(ch2_period),
    .ch2_duty(ch2_duty), .ch2_brake_high(ch2_brake_high),
    .bridge_outputs_a_hs(a_hs), .bridge_outputs_a_ls(a_ls),
    .bridge_outputs_b_hs(b_hs), .bridge_outputs_b_ls(b_ls)
  );
  dc_motor_model motor_a (.ref_clk(ref_clk), .rst(rst), .hs(a_hs), .ls(a_ls), .shoot(sa));
  dc_motor_model motor_b (.ref_clk(ref_clk), .rst(rst), .hs(b_hs), .ls(b_ls), .shoot(sb));

  task automatic summarize;
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(string s, word_t e, word_t g);
    total_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", s, e, g);
      n_fail++;
    end
  endtask

  task automatic wr(addr_t a, word_t d);
    @(posedge ref_clk) #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge ref_clk) #1 reg_wr = 1'b0;
  endtask

  // read data stands until the next read, so it is sampled one edge late
  task automatic rd(addr_t a, output word_t d);
    @(posedge ref_clk) #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge ref_clk) #1 reg_rd = 1'b0;
    @(posedge ref_clk) #1 d = reg_rdata;
  endtask

  task automatic cnt(int w, logic [3:0] pa, logic [3:0] pb);
    na = 0;
    nb = 0;
    repeat (w) begin
      @(posedge ref_clk) #1;
      na += int'({a_hs, a_ls} === pa);
      nb += int'({b_hs, b_ls} === pb);
    end
  endtask

  initial begin
    #(8 * 20000);
    n_fail++;
    summarize();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    #1 rst = 1'b0;
    // host keeps duty within period except in the row that probes duty above period
    foreach (rows[i]) begin
      ch1_brake_high = rows[i].bh;
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, v);
      chk("rdata", rows[i].r, v);
      repeat (40) @(posedge ref_clk);
      cnt(40, rows[i].p, 4'h0);
      chk("gates_a", word_t'(rows[i].n), word_t'(na));
    end
    // channel 1 at ratio 2 with a turn-on delay: period 8 cycles, on 2 of them
    ch1_div = 2'h1;
    ch1_delay = 11'h005;
    wr(7'h07, 32'h4018_0100);
    repeat (40) @(posedge ref_clk);
    cnt(16, 4'h6, 4'h0);
    chk("ch1_div", 32'h0000_0004, word_t'(na));
    wr(7'h07, 32'h0018_0100);
    ch2_mode = 2'h1;
    ch2_period = 11'h003;
    ch2_duty = 11'h001;
    for (int k = 0; k < 4; k++) begin
      wr(7'h06, word_t'(k) << 30);
      repeat (200) @(posedge ref_clk);
      cnt(8 * ratio[k], 4'h0, 4'h6);
      chk("div_b", word_t'(2 * ratio[k]), word_t'(nb));
      chk("pair_a", word_t'(8 * ratio[k]), word_t'(na));
    end
    // external clock at half rate under ratio 2: a base tick every fourth cycle, on 4 of 16
    wr(7'h06, 32'h4000_0000);
    nb = 0;
    for (int j = 0; j < 232; j++) begin
      @(posedge ref_clk) #1 ext_tick = ~ext_tick;
      if (j >= 200) begin
        nb += int'({b_hs, b_ls} === 4'h6);
      end
    end
    chk("ext_half", 32'h0000_0008, word_t'(nb));
    ch2_mode = 2'h0;
    ch2_duty = 11'h003;
    wr(7'h06, 32'h0000_0A00);
    repeat (40) @(posedge ref_clk);
    @(posedge ref_clk) #1 ch2_mode = 2'h1;
    cnt(10, 4'h0, 4'h0);
    chk("dly_off", 32'h0000_000A, word_t'(nb));
    cnt(12, 4'h0, 4'h6);
    chk("dly_on", 32'h0000_000B, word_t'(nb));
    chk("shoot_a", 32'h0000_0000, word_t'(sa));
    chk("shoot_b", 32'h0000_0000, word_t'(sb));
    // second reset in mid-run with channel 2 driving
    @(posedge ref_clk) #1 rst = 1'b1;
    #1 chk("rst_gates", 32'h0000_0000, word_t'({a_hs, a_ls, b_hs, b_ls}));
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'b0;
    rd(7'h06, v);
    chk("rst_cfg2", 32'h0000_0000, v);
    rd(7'h07, v);
    chk("rst_cfg1", 32'h0000_0000, v);
    summarize();
  end
endmodule
